// File: rtl/tsw_device.sv
// Time slot interchange switch: clocking, data banks, connection memory and host port.
`timescale 1ns/1ps
`default_nettype none
module tsw_device (
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  tsw_if.dev               link,
  output logic             o_frame_start,
  output logic             o_wr_bank
);
  import tsw_pkg::*;

  // ---------------------------------------------------------------------------
  // Bit clock and frame timing
  // ---------------------------------------------------------------------------
  logic       ref_prev_r;
  logic       bclk_r;
  logic [7:0] bit_cnt_r;
  logic       bank_r;
  logic       fsync_r;
  logic       ref_rise;
  logic       rise_en;
  logic       fall_en;
  logic       frame_wrap;
  logic [7:0] bit_nxt;

  assign ref_rise   = link.ref_clk & ~ref_prev_r;
  assign rise_en    = ref_rise & ~bclk_r;
  assign fall_en    = ref_rise & bclk_r;
  assign frame_wrap = rise_en && (bit_cnt_r == BIT_CNT_END);
  assign bit_nxt    = bit_cnt_r + 8'h01;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ref_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= link.ref_clk;
    end
  end

  // Each reference rise flips the bit clock, halving 4.096 MHz to 2.048 MHz.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      bclk_r <= 1'b0;
    end else if (ref_rise) begin
      bclk_r <= ~bclk_r;
    end
  end

  // The counter starts at the last bit so the first rise opens a clean frame.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      bit_cnt_r <= BIT_CNT_RST;
    end else if (rise_en) begin
      bit_cnt_r <= bit_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      bank_r <= 1'b0;
    end else if (frame_wrap) begin
      bank_r <= ~bank_r;
    end
  end

  // Frame sync is high for the whole first bit period of each frame.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      fsync_r <= 1'b0;
    end else if (rise_en) begin
      fsync_r <= (bit_cnt_r == BIT_CNT_END);
    end
  end

  assign link.bit_clk    = bclk_r;
  assign link.frame_sync = fsync_r;
  assign o_frame_start   = frame_wrap;
  assign o_wr_bank       = bank_r;

  // ---------------------------------------------------------------------------
  // Host port
  // ---------------------------------------------------------------------------
  logic       hclk_prev_r;
  logic       hp_access;
  logic       hp_write;
  logic       hp_read;
  logic       addr_is_delay;
  logic [8:0] rdata_r;
  logic [7:0] conn_r  [N_CHAN];
  logic [8:0] delay_r [N_STREAMS];

  assign hp_access     = link.host_port_clock & ~hclk_prev_r & link.host_select;
  assign hp_write      = hp_access & ~link.host_read_not_write;
  assign hp_read       = hp_access & link.host_read_not_write;
  assign addr_is_delay = (link.host_address_bus >= DELAY_BASE) &&
                         (link.host_address_bus <= DELAY_LAST);

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      hclk_prev_r <= 1'b0;
    end else begin
      hclk_prev_r <= link.host_port_clock;
    end
  end

  // Addresses below the delay block index the connection memory directly.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < N_CHAN; i++) begin
        conn_r[i] <= CONN_RST;
      end
    end else if (hp_write && !link.host_address_bus[DELAY_ADDR_BIT]) begin
      conn_r[link.host_address_bus[7:0]] <= link.host_write_data[7:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < N_STREAMS; i++) begin
        delay_r[i] <= DELAY_RST;
      end
    end else if (hp_write && addr_is_delay) begin
      delay_r[link.host_address_bus[2:0]] <= link.host_write_data;
    end
  end

  // Unmapped addresses read as zero; a read leaves the bus value until the next read.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rdata_r <= RDATA_RST;
    end else if (hp_read) begin
      if (!link.host_address_bus[DELAY_ADDR_BIT]) begin
        rdata_r <= {1'b0, conn_r[link.host_address_bus[7:0]]};
      end else if (addr_is_delay) begin
        rdata_r <= delay_r[link.host_address_bus[2:0]];
      end else begin
        rdata_r <= RDATA_RST;
      end
    end
  end

  assign link.host_read_data = rdata_r;

  // ---------------------------------------------------------------------------
  // Receive side: capture into the write bank
  // ---------------------------------------------------------------------------
  logic [7:0] rx_sh_r [N_STREAMS];
  logic [7:0] pos_w   [N_STREAMS];
  logic [7:0] dmem_r  [2][N_CHAN];

  // Bit position within the frame as seen by a stream after its delay.
  function automatic logic [7:0] rx_pos(input logic [7:0] cnt, input logic [8:0] dly);
    return cnt - dly[7:0];
  endfunction : rx_pos

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      for (int s = 0; s < N_STREAMS; s++) begin
        rx_sh_r[s] <= 8'h00;
      end
    end else if (fall_en) begin
      for (int s = 0; s < N_STREAMS; s++) begin
        rx_sh_r[s] <= {rx_sh_r[s][6:0], link.serial_in_lines[s]};
      end
    end
  end

  always_comb begin
    for (int s = 0; s < N_STREAMS; s++) begin
      pos_w[s] = rx_pos(bit_cnt_r, delay_r[s]);
    end
  end

  // A delayed stream whose last slot lands after the swap writes into the new
  // bank; offsets are meant to stay small against the frame length.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      for (int b = 0; b < 2; b++) begin
        for (int c = 0; c < N_CHAN; c++) begin
          dmem_r[b][c] <= 8'h00;
        end
      end
    end else if (fall_en) begin
      for (int s = 0; s < N_STREAMS; s++) begin
        if (pos_w[s][2:0] == SLOT_LAST_BIT) begin
          dmem_r[bank_r][tsw_chan_idx(3'(s), pos_w[s][7:3])] <=
            {rx_sh_r[s][6:0], link.serial_in_lines[s]};
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit side: connection memory selects each output slot's source
  // ---------------------------------------------------------------------------
  logic [7:0] tx_sh_r [N_STREAMS];
  logic       rd_bank;
  logic [7:0] tx_bits;

  // On the frame's first rise the banks swap, so the old write bank is read.
  assign rd_bank = (bit_nxt == 8'h00) ? bank_r : ~bank_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      for (int s = 0; s < N_STREAMS; s++) begin
        tx_sh_r[s] <= 8'h00;
      end
    end else if (rise_en) begin
      for (int s = 0; s < N_STREAMS; s++) begin
        if (bit_nxt[2:0] == 3'h0) begin
          tx_sh_r[s] <=
            dmem_r[rd_bank][conn_r[tsw_chan_idx(3'(s), bit_nxt[7:3])]];
        end else begin
          tx_sh_r[s] <= {tx_sh_r[s][6:0], 1'b0};
        end
      end
    end
  end

  always_comb begin
    tx_bits = 8'h00;
    for (int s = 0; s < N_STREAMS; s++) begin
      tx_bits[s] = tx_sh_r[s][7];
    end
  end

  assign link.serial_out_lines = tx_bits;

endmodule : tsw_device
`default_nettype wire

// File: rtl/tsw_host.sv
// Host end: reference clock source, stream source and sink, queued host port master.
`timescale 1ns/1ps
`default_nettype none
module tsw_fifo #(
  parameter int W     = 19,
  parameter int DEPTH = 32
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] rd_r;
  logic [PW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign o_in_ready  = (cnt_r != (PW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem_r[rd_r];

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_r[wr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= push ? PW'(wr_r + 1'b1) : wr_r;
      rd_r  <= pop ? PW'(rd_r + 1'b1) : rd_r;
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : tsw_fifo

module tsw_host (
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  tsw_if.host              link,
  input  wire logic        i_cmd_valid,
  output logic             o_cmd_ready,
  input  wire logic        i_cmd_read,
  input  wire logic [8:0]  i_cmd_addr,
  input  wire logic [8:0]  i_cmd_wdata,
  output logic             o_rd_valid,
  output logic [8:0]       o_rd_data,
  input  wire logic [7:0]  i_serial_drive,
  output logic [7:0]       o_serial_seen,
  output logic             o_bit_rise
);
  import tsw_pkg::*;

  typedef enum {HS_IDLE, HS_READ, HS_WRITE} tsw_hstate_e;

  // ---------------------------------------------------------------------------
  // Reference clock and serial lines
  // ---------------------------------------------------------------------------
  logic [REF_ACC_W-1:0] acc_r;
  logic                 ref_r;
  logic                 bclk_prev_r;
  logic [7:0]           sin_r;
  logic [7:0]           seen_r;
  logic                 carry;
  logic [REF_ACC_W-1:0] acc_sum;

  assign {carry, acc_sum} = {1'b0, acc_r} + {1'b0, REF_INC};

  // Phase accumulator: the pin averages 4.096 MHz with one core cycle of jitter.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      acc_r <= '0;
      ref_r <= 1'b0;
    end else begin
      acc_r <= acc_sum;
      ref_r <= carry ? ~ref_r : ref_r;
    end
  end

  assign o_bit_rise = link.bit_clk & ~bclk_prev_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      bclk_prev_r <= 1'b0;
      sin_r       <= 8'h00;
      seen_r      <= 8'h00;
    end else begin
      bclk_prev_r <= link.bit_clk;
      if (o_bit_rise) begin
        sin_r <= i_serial_drive;
      end
      if (!link.bit_clk && bclk_prev_r) begin
        seen_r <= link.serial_out_lines;
      end
    end
  end

  assign link.ref_clk         = ref_r;
  assign link.serial_in_lines = sin_r;
  assign o_serial_seen        = seen_r;

  // ---------------------------------------------------------------------------
  // Host port master
  // ---------------------------------------------------------------------------
  logic [HP_PHASE_W-1:0] ph_r;
  tsw_hstate_e           st_r;
  logic                  q_valid;
  logic                  q_pop;
  logic [CMD_W-1:0]      q_data;
  logic [CMD_W-1:0]      cmd_r;
  logic [8:0]            rd_r;
  logic                  rdv_r;

  // Each command holds for one full host clock period; the queue absorbs bursts.
  tsw_fifo #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) u_cmd_q (
    .i_core_clk  (i_core_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_cmd_valid),
    .o_in_ready  (o_cmd_ready),
    .i_in_data   ({i_cmd_read, i_cmd_addr, i_cmd_wdata}),
    .o_out_valid (q_valid),
    .i_out_ready (q_pop),
    .o_out_data  (q_data)
  );

  assign q_pop = (ph_r == '1);

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ph_r <= '0;
    end else begin
      ph_r <= ph_r + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      st_r  <= HS_IDLE;
      cmd_r <= '0;
    end else if (q_pop) begin
      cmd_r <= q_valid ? q_data : '0;
      if (!q_valid) begin
        st_r <= HS_IDLE;
      end else if (q_data[CMD_W-1]) begin
        st_r <= HS_READ;
      end else begin
        st_r <= HS_WRITE;
      end
    end
  end

  // Read data is taken at the end of the high half, one cycle after the device latched it.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rd_r  <= 9'h000;
      rdv_r <= 1'b0;
    end else begin
      rdv_r <= 1'b0;
      case (st_r)
        HS_READ: begin
          if (q_pop) begin
            rd_r  <= link.host_read_data;
            rdv_r <= 1'b1;
          end
        end
        HS_IDLE, HS_WRITE: begin
          rdv_r <= 1'b0;
        end
        default: begin
          rdv_r <= 1'b0;
        end
      endcase
    end
  end

  assign link.host_port_clock     = ph_r[HP_PHASE_W-1];
  assign link.host_select         = (st_r != HS_IDLE);
  assign link.host_read_not_write = cmd_r[CMD_W-1];
  assign link.host_address_bus    = cmd_r[DATA_W +: ADDR_W];
  assign link.host_write_data     = cmd_r[DATA_W-1:0];
  assign o_rd_valid               = rdv_r;
  assign o_rd_data                = rd_r;

endmodule : tsw_host
`default_nettype wire

// File: rtl/tsw_if.sv
// Pin-level carrier joining the switch and its host end.
`timescale 1ns/1ps
`default_nettype none
interface tsw_if;
  logic       ref_clk;
  logic       bit_clk;
  logic       frame_sync;
  logic [7:0] serial_in_lines;
  logic [7:0] serial_out_lines;
  logic       host_port_clock;
  logic       host_read_not_write;
  logic       host_select;
  logic [8:0] host_address_bus;
  logic [8:0] host_write_data;
  logic [8:0] host_read_data;

  modport dev (
    input  ref_clk, serial_in_lines, host_port_clock, host_read_not_write,
    input  host_select, host_address_bus, host_write_data,
    output bit_clk, frame_sync, serial_out_lines, host_read_data
  );

  modport host (
    output ref_clk, serial_in_lines, host_port_clock, host_read_not_write,
    output host_select, host_address_bus, host_write_data,
    input  bit_clk, frame_sync, serial_out_lines, host_read_data
  );
endinterface : tsw_if
`default_nettype wire

// File: rtl/tsw_pkg.sv
// Shared constants, types and helper functions for the time slot switch and its host end.
package tsw_pkg;

  // ---------------------------------------------------------------------------
  // Rates and timing
  // ---------------------------------------------------------------------------
  localparam longint CORE_CLK_HZ  = 10_000_000;
  localparam longint REF_CLK_HZ   = 4_096_000;
  localparam longint BIT_RATE_HZ  = 2_048_000;
  localparam int     FRAME_US     = 125;
  localparam int     REF_ACC_W    = 32;
  // Phase increment that toggles the reference pin at twice its frequency.
  localparam logic [REF_ACC_W-1:0] REF_INC =
    REF_ACC_W'(((2 * REF_CLK_HZ) << REF_ACC_W) / CORE_CLK_HZ);
  localparam int     HP_PHASE_W   = 2;

  // ---------------------------------------------------------------------------
  // Frame geometry
  // ---------------------------------------------------------------------------
  localparam int N_STREAMS      = 8;
  localparam int N_SLOTS        = 32;
  localparam int SLOT_BITS      = 8;
  localparam int BITS_PER_FRAME = int'((BIT_RATE_HZ * FRAME_US) / 1_000_000);
  localparam int N_CHAN         = N_STREAMS * N_SLOTS;
  localparam logic [7:0] BIT_CNT_RST = 8'hFF;
  localparam logic [7:0] BIT_CNT_END = 8'hFF;
  localparam logic [2:0] SLOT_LAST_BIT = 3'h7;

  // ---------------------------------------------------------------------------
  // Host port map
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 9;
  localparam int DELAY_ADDR_BIT = 8;
  localparam logic [ADDR_W-1:0] DELAY_BASE = 9'h100;
  localparam logic [ADDR_W-1:0] DELAY_LAST = 9'h107;
  localparam logic [7:0]        CONN_RST   = 8'h00;
  localparam logic [DATA_W-1:0] DELAY_RST  = 9'h000;
  localparam logic [DATA_W-1:0] RDATA_RST  = 9'h000;

  // ---------------------------------------------------------------------------
  // Host command queue
  // ---------------------------------------------------------------------------
  localparam int FIFO_DEPTH = 32;
  localparam int CMD_W      = 1 + ADDR_W + DATA_W;

  typedef logic [7:0] tsw_chan_t;

  // Channel index: stream number in the top three bits, slot in the low five.
  function automatic tsw_chan_t tsw_chan_idx(input logic [2:0] stream,
                                             input logic [4:0] slot);
    return {stream, slot};
  endfunction : tsw_chan_idx

endpackage : tsw_pkg

// File: tb/tdm_time_slot_switch_tb.sv
// Self-checking bench: host end and switch joined, host port and stream switching checked.
`timescale 1ns/1ps
`default_nettype none
module tdm_time_slot_switch_tb;
  import tsw_pkg::*;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_read = 1'b0;
  logic [8:0] cmd_addr = 9'h000;
  logic [8:0] cmd_wdata = 9'h000;
  logic [7:0] serial_drive = 8'h00;
  logic       cmd_ready, rd_valid, frame_start, wr_bank, bit_rise;
  logic [8:0] rd_data;
  logic [7:0] in_byte [256];
  logic [7:0] conn_m [256];
  logic [8:0] dly [8];
  logic [7:0] obyte [8];
  logic [7:0] serial_seen, sx = 8'h00;
  logic       sx_on = 1'b0;
  logic [8:0] exp_q [$];
  logic [7:0] ipos = 8'h00;
  logic [7:0] opos = 8'h00;
  logic       bc_q = 1'b0, wb_q = 1'b0, pend = 1'b0, chk_on = 1'b0, full_seen = 1'b0;
  int         errors = 0, comparisons = 0, seed = 32'hC08C;

  always #50 core_clk = ~core_clk;

  tsw_if link ();
  tsw_device u_tsw_device (.i_core_clk(core_clk), .i_nrst(nrst), .link(link.dev),
    .o_frame_start(frame_start), .o_wr_bank(wr_bank));
  tsw_host u_tsw_host (.i_core_clk(core_clk), .i_nrst(nrst), .link(link.host),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_read(cmd_read),
    .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .i_serial_drive(serial_drive), .o_serial_seen(serial_seen),
    .o_bit_rise(bit_rise));
  tsw_chk u_chk (.i_core_clk(core_clk), .i_nrst(nrst), .bit_clk(link.bit_clk),
    .frame_sync(link.frame_sync), .serial_out_lines(link.serial_out_lines),
    .host_port_clock(link.host_port_clock), .host_read_not_write(link.host_read_not_write),
    .host_select(link.host_select), .host_address_bus(link.host_address_bus),
    .host_write_data(link.host_write_data), .host_read_data(link.host_read_data));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Valid stays high between back-to-back calls; drain lowers it.
  task automatic push(input logic rd, input logic [8:0] a, input logic [8:0] d,
                      input logic [8:0] e);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_addr  <= a;
    cmd_wdata <= d;
    if (rd) exp_q.push_back(e);
    @(negedge core_clk);
    while (!cmd_ready && n < 500) begin
      full_seen = 1'b1;
      n++;
      @(negedge core_clk);
    end
    if (!cmd_ready) errors++;
    @(posedge core_clk);
  endtask : push

  task automatic drain();
    int n;
    n = 0;
    cmd_valid <= 1'b0;
    while (exp_q.size() > 0 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    if (exp_q.size() > 0) errors++;
  endtask : drain

  task automatic wait_frames(input int k);
    int n, c;
    n = 0;
    c = 0;
    while (c < k && n < 20000) begin
      @(posedge core_clk);
      n++;
      if (frame_start) c++;
    end
    if (c < k) errors++;
  endtask : wait_frames

  // ---------------------------------------------------------------------------
  // Stream source, stream sink and read monitor
  // ---------------------------------------------------------------------------
  // The bit taken at this rise is already on the line, so the next one is prepared.
  always @(posedge core_clk) begin : src
    logic [7:0] ip, n;
    if (bit_rise) begin
      ip = link.frame_sync ? 8'h00 : ipos + 8'h01;
      n = ip + 8'h01;
      ipos <= ip;
      for (int s = 0; s < 8; s++) begin
        serial_drive[s] <= in_byte[{s[2:0], n[7:3]}][3'h7 - n[2:0]];
      end
    end
  end

  always @(posedge core_clk) begin : sink
    logic [7:0] sc, ex;
    bc_q <= link.bit_clk;
    // The host end latches the line at the same fall; it is compared one cycle on.
    sx_on <= !link.bit_clk && bc_q && nrst;
    sx <= link.serial_out_lines;
    if (sx_on) check({1'b0, serial_seen}, {1'b0, sx});
    if (link.bit_clk && !bc_q) opos <= link.frame_sync ? 8'h00 : opos + 8'h01;
    if (!link.bit_clk && bc_q) begin
      for (int s = 0; s < 8; s++) begin
        obyte[s] = {obyte[s][6:0], link.serial_out_lines[s]};
        if (chk_on && opos[2:0] == 3'h7) begin
          sc = conn_m[{s[2:0], opos[7:3]}];
          ex = in_byte[{sc[7:5], 5'(sc[4:0] + dly[sc[7:5]][7:3])}];
          check({1'b0, obyte[s]}, {1'b0, ex});
        end
      end
    end
  end

  always @(posedge core_clk) begin : bank
    pend <= frame_start && nrst;
    wb_q <= wr_bank;
    if (pend && nrst) check({7'h00, wr_bank, link.frame_sync}, {7'h00, ~wb_q, 1'b1});
  end

  always @(posedge core_clk) begin : rd_mon
    if (rd_valid) check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data);
  end

  initial begin : watchdog
    repeat (40000) @(posedge core_clk);
    errors++;
    end_sim();
  end

  initial begin : main
    logic [8:0] wd;
    for (int i = 0; i < N_CHAN; i++) begin
      in_byte[i] = 8'($random(seed));
      conn_m[i] = 8'h00;
    end
    for (int i = 0; i < N_STREAMS; i++) dly[i] = 9'h000;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    push(1'b1, 9'h000, 9'h000, 9'h000);
    push(1'b1, 9'h0FF, 9'h000, 9'h000);
    push(1'b1, 9'h107, 9'h000, 9'h000);
    dly[3] = 9'h008;
    dly[5] = 9'h100;
    dly[6] = 9'h0F8;
    for (int i = 0; i < N_STREAMS; i++) push(1'b0, DELAY_BASE + 9'(i), dly[i], 9'h000);
    for (int i = 0; i < N_CHAN; i++) begin
      wd = 9'($random(seed));
      conn_m[i] = wd[7:0];
      push(1'b0, 9'(i), wd, 9'h000);
    end
    // Addresses past the delay block ignore writes and read as zero.
    push(1'b0, 9'h12C, 9'h0AA, 9'h000);
    push(1'b1, 9'h12C, 9'h000, 9'h000);
    push(1'b1, 9'h1FF, 9'h000, 9'h000);
    for (int i = 0; i < N_STREAMS; i++) push(1'b1, DELAY_BASE + 9'(i), 9'h000, dly[i]);
    drain();
    check({8'h00, full_seen}, 9'h001);
    wait_frames(3);
    chk_on <= 1'b1;
    wait_frames(2);
    chk_on <= 1'b0;
    for (int i = 0; i < N_CHAN; i++) push(1'b1, 9'(i), 9'h000, {1'b0, conn_m[i]});
    drain();
    nrst <= 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    push(1'b1, 9'h005, 9'h000, 9'h000);
    push(1'b1, 9'h103, 9'h000, 9'h000);
    drain();
    end_sim();
  end
endmodule : tdm_time_slot_switch_tb
`default_nettype wire

// File: tb/tsw_chk.sv
// Concurrent checks on the link between the switch and its host end.
`timescale 1ns/1ps
`default_nettype none
module tsw_chk (
  input wire logic       i_core_clk,
  input wire logic       i_nrst,
  input wire logic       bit_clk,
  input wire logic       frame_sync,
  input wire logic [7:0] serial_out_lines,
  input wire logic       host_port_clock,
  input wire logic       host_read_not_write,
  input wire logic       host_select,
  input wire logic [8:0] host_address_bus,
  input wire logic [8:0] host_write_data,
  input wire logic [8:0] host_read_data
);
  logic        hclk_prev_r;
  logic        rd_take_r;
  logic        fsync_prev_r;
  logic        seen_r;
  logic [10:0] fcnt_r;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  // ---------------------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------------------
  // A read strobe as the switch sees it: select high at a sampled host clock rise.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      hclk_prev_r <= 1'b0;
      rd_take_r   <= 1'b0;
    end else begin
      hclk_prev_r <= host_port_clock;
      rd_take_r   <= host_port_clock & ~hclk_prev_r & host_select & host_read_not_write;
    end
  end

  // The first sync after reset has no predecessor, so the count ending there is not judged.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      fsync_prev_r <= 1'b0;
      seen_r       <= 1'b0;
      fcnt_r       <= 11'h000;
    end else begin
      fsync_prev_r <= frame_sync;
      if (frame_sync & ~fsync_prev_r) begin
        seen_r <= 1'b1;
        fcnt_r <= 11'h001;
      end else begin
        fcnt_r <= fcnt_r + 11'h001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  sequence port_cycle_s;
    host_port_clock [*2] ##1 !host_port_clock [*2] ##1 host_port_clock;
  endsequence
  sequence pins_hold_s;
    ($stable(host_address_bus) && $stable(host_write_data)
      && $stable(host_read_not_write) && $stable(host_select)) [*2];
  endsequence

  bit_half_a: assert property ($rose(bit_clk) |-> ##[2:3] $fell(bit_clk))
    else $error("bit clock half period out of range");
  frame_len_a: assert property (frame_sync && !fsync_prev_r && seen_r |->
    fcnt_r inside {[1248:1252]})
    else $error("frame length out of range");
  sync_width_a: assert property ($rose(frame_sync) |-> ##[4:6] $fell(frame_sync))
    else $error("frame sync not one bit period wide");
  sync_start_a: assert property ($rose(frame_sync) |-> $rose(bit_clk))
    else $error("frame sync rose off a bit clock rise");
  sync_end_a: assert property ($fell(frame_sync) |-> $rose(bit_clk))
    else $error("frame sync fell off a bit clock rise");
  tx_launch_a: assert property ($changed(serial_out_lines) |-> $rose(bit_clk))
    else $error("serial output changed off a bit clock rise");
  read_data_a: assert property ($changed(host_read_data) |-> rd_take_r)
    else $error("read data changed without a selected read");
  port_clock_a: assert property ($rose(host_port_clock) |-> port_cycle_s)
    else $error("host port clock period wrong");
  port_pins_a: assert property ($rose(host_port_clock) |-> pins_hold_s)
    else $error("host port pins moved around the clock rise");
endmodule : tsw_chk
`default_nettype wire
